// ---- hw/uart_multiprocessor_core.sv ----
// Asynchronous serial transmitter and receiver with idle-line and address-bit framing.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "uart_mp_defs.svh"

module uart_multiprocessor_core #(
    parameter int OVERSAMPLE = 16
) (
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_b_in,
    // Register port
    input  wire logic [`ADDR_W-1:0]   reg_addr_in,
    input  wire logic [15:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic      [15:0]          reg_rdata_out,
    // Serial pins
    input  wire logic                 serial_rx_pin_in,
    output logic                      serial_tx_pin_out
);
    localparam int HALF = OVERSAMPLE / 2;

    logic [15:0] ctrl_q;
    logic [15:0] baud_q;
    logic [3:0]  ie_q;
    logic [15:0] baud_cnt_q;
    logic        tick;
    logic        swrst;
    logic        wr_tx;
    logic        rd_rx;
    logic        bit_lsb_first;
    logic        seven;
    logic        addr_mode;
    logic        idle_mode;
    logic [3:0]  nbits;
    logic        tx_clr_addr;
    logic        tx_clr_brk;
    uart_mp_pkg::frame_mode_t mode;

    assign swrst         = ctrl_q[`CTRL_SWRST];
    assign bit_lsb_first = ~ctrl_q[`CTRL_MSB];
    assign seven         = ctrl_q[`CTRL_SEVEN];
    assign mode          = uart_mp_pkg::frame_mode_t'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    assign idle_mode     = (mode == uart_mp_pkg::MODE_IDLE_LINE);
    assign addr_mode     = (mode == uart_mp_pkg::MODE_ADDR_BIT);
    assign wr_tx         = reg_wr_in && (reg_addr_in == `REG_TXBUF);
    assign rd_rx         = reg_rd_in && (reg_addr_in == `REG_RXBUF);
    // Frame bits after start: data, address, parity, stops.
    assign nbits = (seven ? 4'h7 : 4'h8) + {3'h0, addr_mode} + {3'h0, ctrl_q[`CTRL_PEN]}
                   + (ctrl_q[`CTRL_SPB] ? 4'h2 : 4'h1);

    // Reset value keeps the soft reset bit set after power-up clear.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            ctrl_q <= `CTRL_RESET;
        else if (reg_wr_in && reg_addr_in == `REG_CTRL)
            ctrl_q <= reg_wdata_in;
        else
        begin
            if (tx_clr_addr)
                ctrl_q[`CTRL_TXADDR] <= 1'b0;
            if (tx_clr_brk)
                ctrl_q[`CTRL_TXBRK] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            baud_q <= `BAUD_RESET;
        else if (reg_wr_in && reg_addr_in == `REG_BAUD)
            baud_q <= reg_wdata_in;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
            ie_q <= 4'h0;
        else if (reg_wr_in && reg_addr_in == `REG_IE)
            ie_q <= reg_wdata_in[3:0];
    end

    // Shared oversampling tick; stopped while the soft reset bit or the sync bit is set.
    logic rx_halt;
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst || baud_cnt_q >= baud_q)
            baud_cnt_q <= 16'h0000;
        else
            baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
    assign tick = (baud_cnt_q >= baud_q) && !swrst && !ctrl_q[`CTRL_SYNC];

    // Transmitter.
    logic        tx_full_q;
    logic [7:0]  tx_buf_q;
    logic [10:0] tx_sh_q;
    logic [3:0]  tx_bits_q;
    logic [3:0]  tx_gap_q;
    logic [7:0]  tx_os_q;
    logic        tx_q;
    logic        tx_load;
    logic        tx_start_now;
    logic [7:0]  tx_data;
    logic        tx_par;
    uart_mp_pkg::tx_state_t tx_st_q;

    function automatic logic [7:0] order(input logic [7:0] d, input logic lsb, input logic sev);
        logic [7:0] r;
        r = d;
        if (!lsb)
            r = sev ? {1'b0, d[0], d[1], d[2], d[3], d[4], d[5], d[6]}
                    : {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
        return r;
    endfunction : order

    assign tx_load     = tick && (tx_os_q == 8'h00) && tx_full_q
                         && (tx_st_q == uart_mp_pkg::TX_IDLE);
    assign tx_data     = ctrl_q[`CTRL_TXBRK] ? 8'h00 : order(tx_buf_q, bit_lsb_first, seven);
    assign tx_par      = ^tx_buf_q[6:0] ^ (seven ? 1'b0 : tx_buf_q[7])
                         ^ (addr_mode & ctrl_q[`CTRL_TXADDR]) ^ ~ctrl_q[`CTRL_PEVEN];
    assign tx_clr_addr = tx_start_now && ctrl_q[`CTRL_TXADDR] && (idle_mode || addr_mode);
    assign tx_clr_brk  = tx_start_now && ctrl_q[`CTRL_TXBRK];

    assign tx_start_now = tx_load && !(idle_mode && ctrl_q[`CTRL_TXADDR])
                          || (tick && tx_os_q == 8'h00 && tx_st_q == uart_mp_pkg::TX_GAP
                              && tx_gap_q == 4'h1);

    logic [10:0] frame;
    always_comb
    begin
        frame = 11'h7FF;
        if (seven)
            frame[6:0] = tx_data[6:0];
        else
            frame[7:0] = tx_data;
        // Address bit then parity follow data, stops fill the rest with ones.
        frame[seven ? 7 : 8] = 1'b1;
        if (addr_mode)
            frame[seven ? 7 : 8] = ctrl_q[`CTRL_TXADDR] & ~ctrl_q[`CTRL_TXBRK];
        if (ctrl_q[`CTRL_PEN])
            frame[(seven ? 4'd7 : 4'd8) + {3'h0, addr_mode}] = tx_par & ~ctrl_q[`CTRL_TXBRK];
        if (ctrl_q[`CTRL_TXBRK])
            frame = frame & ~((11'h001 << nbits) - 11'h001);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
        begin
            tx_st_q   <= uart_mp_pkg::TX_IDLE;
            tx_os_q   <= 8'h00;
            tx_q      <= 1'b1;
            tx_sh_q   <= 11'h7FF;
            tx_bits_q <= 4'h0;
            tx_gap_q  <= 4'h0;
        end
        else if (tick)
        begin
            tx_os_q <= (tx_os_q == 8'(OVERSAMPLE - 1)) ? 8'h00 : tx_os_q + 8'h01;
            if (tx_os_q == 8'h00)
            begin
                case (tx_st_q)
                    uart_mp_pkg::TX_IDLE:
                    begin
                        if (tx_load && idle_mode && ctrl_q[`CTRL_TXADDR])
                        begin
                            tx_st_q  <= uart_mp_pkg::TX_GAP;
                            tx_gap_q <= `IDLE_TX_BITS;
                            tx_q     <= 1'b1;
                        end
                        else if (tx_load)
                        begin
                            tx_st_q   <= uart_mp_pkg::TX_SEND;
                            tx_q      <= 1'b0;
                            tx_sh_q   <= frame;
                            tx_bits_q <= nbits;
                        end
                    end
                    uart_mp_pkg::TX_GAP:
                    begin
                        tx_gap_q <= tx_gap_q - 4'h1;
                        if (tx_gap_q == 4'h1)
                        begin
                            tx_st_q   <= uart_mp_pkg::TX_SEND;
                            tx_q      <= 1'b0;
                            tx_sh_q   <= frame;
                            tx_bits_q <= nbits;
                        end
                    end
                    uart_mp_pkg::TX_SEND:
                    begin
                        if (tx_bits_q == 4'h0)
                        begin
                            tx_st_q <= uart_mp_pkg::TX_IDLE;
                            tx_q    <= 1'b1;
                        end
                        else
                        begin
                            tx_q      <= tx_sh_q[0];
                            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                            tx_bits_q <= tx_bits_q - 4'h1;
                        end
                    end
                    default: tx_st_q <= uart_mp_pkg::TX_IDLE;
                endcase
            end
        end
    end

    // Buffer is released when its character starts on the line.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
            tx_full_q <= 1'b0;
        else if (wr_tx)
            tx_full_q <= 1'b1;
        else if (tx_start_now)
            tx_full_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            tx_buf_q <= 8'h00;
        else if (wr_tx)
            tx_buf_q <= reg_wdata_in[7:0];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            serial_tx_pin_out <= 1'b1;
        else
            serial_tx_pin_out <= tx_q;
    end

    // Receiver.
    logic [10:0] rx_sh_q;
    logic [3:0]  rx_bits_q;
    logic [7:0]  rx_os_q;
    logic [3:0]  rx_marks_q;
    logic        rx_after_idle_q;
    logic        rx_done;
    logic [7:0]  rx_buf_q;
    logic [15:0] stat_q;
    uart_mp_pkg::rx_state_t rx_st_q;

    logic        mid;
    assign mid  = tick && (rx_os_q == 8'(HALF));
    assign rx_halt = (rx_st_q == uart_mp_pkg::RX_WAIT) && stat_q[`ST_IDLE] && idle_mode;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
        begin
            rx_st_q    <= uart_mp_pkg::RX_WAIT;
            rx_os_q    <= 8'h00;
            rx_bits_q  <= 4'h0;
            rx_sh_q    <= 11'h000;
            rx_marks_q <= 4'h0;
        end
        else
        begin
            case (rx_st_q)
                uart_mp_pkg::RX_WAIT,
                uart_mp_pkg::RX_IDLE_CNT:
                begin
                    if (!serial_rx_pin_in)
                    begin
                        rx_st_q   <= uart_mp_pkg::RX_SHIFT;
                        rx_os_q   <= 8'h00;
                        rx_bits_q <= nbits;
                    end
                    else if (tick && !rx_halt && rx_st_q == uart_mp_pkg::RX_IDLE_CNT)
                    begin
                        rx_os_q <= (rx_os_q == 8'(OVERSAMPLE - 1)) ? 8'h00 : rx_os_q + 8'h01;
                        if (rx_os_q == 8'(OVERSAMPLE - 1))
                        begin
                            rx_marks_q <= rx_marks_q + 4'h1;
                            if (rx_marks_q + 4'h1 == `IDLE_RX_BITS)
                                rx_st_q <= uart_mp_pkg::RX_WAIT;
                        end
                    end
                end
                uart_mp_pkg::RX_SHIFT:
                begin
                    if (tick)
                        rx_os_q <= (rx_os_q == 8'(OVERSAMPLE - 1)) ? 8'h00 : rx_os_q + 8'h01;
                    if (mid)
                    begin
                        // A start bit that reads high at its middle was a glitch: hunt again.
                        if (rx_bits_q == nbits && serial_rx_pin_in)
                            rx_st_q <= uart_mp_pkg::RX_WAIT;
                        rx_sh_q <= {serial_rx_pin_in, rx_sh_q[10:1]};
                        if (rx_bits_q == 4'h0)
                        begin
                            // Starts at all ones so the tail of the stop bit wraps it to zero.
                            rx_st_q    <= uart_mp_pkg::RX_IDLE_CNT;
                            rx_marks_q <= 4'hF;
                        end
                        else
                            rx_bits_q <= rx_bits_q - 4'h1;
                    end
                end
                default: rx_st_q <= uart_mp_pkg::RX_WAIT;
            endcase
        end
    end
    assign rx_done = mid && (rx_st_q == uart_mp_pkg::RX_SHIFT) && (rx_bits_q == 4'h0);

    // Frame is right-aligned after the last shift: start bit sits below the field.
    logic [10:0] fr;
    logic [7:0]  rx_data;
    logic        rx_abit;
    logic        rx_pbit;
    logic        rx_fe;
    logic        rx_pe;
    logic        rx_brk;
    logic        rx_is_addr;
    logic        rx_store;
    logic [3:0]  dn;
    always_comb
    begin
        fr      = {serial_rx_pin_in, rx_sh_q[10:1]} >> (4'd11 - nbits);
        dn      = seven ? 4'h7 : 4'h8;
        rx_data = seven ? {1'b0, fr[6:0]} : fr[7:0];
        if (!bit_lsb_first)
            rx_data = order(rx_data, 1'b0, seven);
        rx_abit = addr_mode & fr[dn];
        rx_pbit = fr[dn + {3'h0, addr_mode}];
        // Stop bits are the top one or two bits of the field.
        rx_fe   = !fr[nbits - 4'h1] || (ctrl_q[`CTRL_SPB] && !fr[nbits - 4'h2]);
        rx_pe   = ctrl_q[`CTRL_PEN]
                  && ((^rx_data ^ rx_abit ^ rx_pbit) != ~ctrl_q[`CTRL_PEVEN]);
        rx_brk  = ((fr & ((11'h001 << nbits) - 11'h001)) == 11'h000);
        rx_is_addr = idle_mode ? rx_after_idle_q : rx_abit;
        // Dormant reads the live bit at completion so a mid-character clear counts.
        if (ctrl_q[`CTRL_DORM] && (idle_mode || addr_mode))
            rx_store = rx_is_addr && (ie_q[`IE_RXE] || !(rx_fe || rx_pe));
        else
            rx_store = 1'b1;
        if (rx_brk)
            rx_store = ie_q[`IE_BRK];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
            rx_after_idle_q <= 1'b0;
        else if (rx_done)
            rx_after_idle_q <= 1'b0;
        else if (rx_st_q == uart_mp_pkg::RX_IDLE_CNT && tick && rx_os_q == 8'(OVERSAMPLE - 1)
                 && rx_marks_q + 4'h1 == `IDLE_RX_BITS)
            rx_after_idle_q <= 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            rx_buf_q <= 8'h00;
        else if (rx_done && rx_store)
            rx_buf_q <= rx_brk ? 8'h00 : rx_data;
    end

    // Status: hardware set wins over a software clear in the same cycle.
    logic [15:0] set_v;
    logic [15:0] clr_v;
    always_comb
    begin
        set_v = 16'h0000;
        clr_v = 16'h0000;
        if (reg_wr_in && reg_addr_in == `REG_STAT)
            clr_v = reg_wdata_in;
        if (rd_rx)
        begin
            clr_v[`ST_RXF] = 1'b1;
            clr_v[`ST_BRK] = 1'b1;
            clr_v[`ST_OE]  = 1'b1;
        end
        if (rx_done && rx_store)
        begin
            set_v[`ST_RXF]  = 1'b1;
            set_v[`ST_OE]   = stat_q[`ST_RXF] && !rd_rx;
            set_v[`ST_FE]   = rx_fe && !rx_brk;
            set_v[`ST_PE]   = rx_pe;
            set_v[`ST_ADDR] = rx_abit && addr_mode;
            set_v[`ST_ERR]  = (rx_fe && !rx_brk) || rx_pe || set_v[`ST_OE];
            clr_v[`ST_IDLE] = !(idle_mode && rx_is_addr);
            clr_v[`ST_ADDR] = 1'b1;
        end
        if (rx_done && rx_brk)
            set_v[`ST_BRK] = 1'b1;
        if (rx_st_q == uart_mp_pkg::RX_IDLE_CNT && tick && rx_os_q == 8'(OVERSAMPLE - 1)
            && rx_marks_q + 4'h1 == `IDLE_RX_BITS && idle_mode)
            set_v[`ST_IDLE] = 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || swrst)
            stat_q <= 16'h0000;
        else
            stat_q <= (stat_q & ~clr_v) | set_v;
    end

    // Read data, one cycle after the read strobe.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `REG_CTRL:  reg_rdata_out <= ctrl_q;
                `REG_BAUD:  reg_rdata_out <= baud_q;
                `REG_STAT:
                begin
                    reg_rdata_out <= stat_q;
                    reg_rdata_out[`ST_TXE]  <= !tx_full_q || swrst;
                    reg_rdata_out[`ST_BUSY] <= tx_st_q != uart_mp_pkg::TX_IDLE;
                end
                `REG_IE:    reg_rdata_out <= {12'h000, ie_q};
                `REG_RXBUF: reg_rdata_out <= {8'h00, rx_buf_q};
                default:    reg_rdata_out <= 16'h0000;
            endcase
        end
        else
            reg_rdata_out <= 16'h0000;
    end
endmodule : uart_multiprocessor_core

// ---- hw/uart_mp_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the serial block.
`ifndef UART_MP_DEFS_SVH
`define UART_MP_DEFS_SVH
`define ADDR_W           4
`define REG_CTRL         4'h0
`define REG_BAUD         4'h1
`define REG_STAT         4'h2
`define REG_IE           4'h3
`define REG_TXBUF        4'h4
`define REG_RXBUF        4'h5
`define CTRL_SWRST       0
`define CTRL_SYNC        1
`define CTRL_MSB         2
`define CTRL_SEVEN       3
`define CTRL_PEN         4
`define CTRL_PEVEN       5
`define CTRL_SPB         6
`define CTRL_MODE_LO     7
`define CTRL_MODE_HI     8
`define CTRL_DORM        9
`define CTRL_TXADDR      10
`define CTRL_TXBRK       11
`define CTRL_RESET       16'h0001
`define ST_TXE           0
`define ST_RXF           1
`define ST_ERR           2
`define ST_BRK           3
`define ST_PE            4
`define ST_OE            5
`define ST_FE            6
`define ST_IDLE          7
`define ST_ADDR          8
`define ST_STOE          9
`define ST_BTOE          10
`define ST_BUSY          11
`define IE_RX            0
`define IE_TX            1
`define IE_RXE           2
`define IE_BRK           3
`define BAUD_RESET       16'h0363
`define IDLE_RX_BITS     4'hA
`define IDLE_TX_BITS     4'hB
`define ALL_ONES_9       9'h1FF
`endif

// ---- hw/uart_mp_pkg.sv ----
// Types shared by the serial block.
package uart_mp_pkg;
    typedef enum logic [1:0] {MODE_PLAIN, MODE_IDLE_LINE, MODE_ADDR_BIT, MODE_AUTO_BAUD} frame_mode_t;
    typedef enum {TX_IDLE, TX_GAP, TX_SEND} tx_state_t;
    typedef enum {RX_WAIT, RX_SHIFT, RX_IDLE_CNT} rx_state_t;
endpackage : uart_mp_pkg

// ---- tb/uart_mp_assertions.sv ----
// Checker of register-port and serial-line relations of the serial core.
`timescale 1ns/10ps
`include "uart_mp_defs.svh"
module uart_mp_checker #(
    parameter int OVERSAMPLE = 16
) (
    // Clock, reset and register port
    input wire logic               ref_clk_in,
    input wire logic               rst_b_in,
    input wire logic [`ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0]        reg_wdata_in,
    input wire logic               reg_wr_in,
    input wire logic               reg_rd_in,
    input wire logic [15:0]        reg_rdata_out,
    // Serial pins
    input wire logic               serial_rx_pin_in,
    input wire logic               serial_tx_pin_out
);
    logic        swrst_q;
    logic [15:0] low_q;
    logic [15:0] high_q;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    always_ff @(posedge ref_clk_in)
        if (!rst_b_in)
            swrst_q <= 1'b1;
        else if (reg_wr_in && reg_addr_in == `REG_CTRL)
            swrst_q <= reg_wdata_in[`CTRL_SWRST];
    // Lengths of the current low and high runs on the transmit line.
    always_ff @(posedge ref_clk_in)
        low_q <= (!rst_b_in || serial_tx_pin_out) ? 16'h0000 : low_q + 16'h0001;
    always_ff @(posedge ref_clk_in)
        high_q <= (!rst_b_in || !serial_tx_pin_out) ? 16'h0000 : high_q + {15'h0000, high_q != 16'hFFFF};
    sequence rd_at(logic [3:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    sequence held_soft_reset;
        swrst_q && $past(swrst_q) && $past(swrst_q, 2);
    endsequence
    AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (rd_at(4'hF) |=> reg_rdata_out == 16'h0000)
        else $error("unmapped index read not zero");
    AST_SWRST_STATUS: assert property (held_soft_reset ##0 rd_at(`REG_STAT) |=> (reg_rdata_out & 16'h067F) == 16'h0001)
        else $error("status wrong under soft reset");
    AST_SWRST_IE: assert property (held_soft_reset ##0 rd_at(`REG_IE) |=> (reg_rdata_out & 16'h0003) == 16'h0000)
        else $error("enables not clear under soft reset");
    AST_SWRST_TX: assert property (held_soft_reset |-> serial_tx_pin_out)
        else $error("transmit line active under soft reset");
    AST_ERR_SUM: assert property (rd_at(`REG_STAT) |=> (reg_rdata_out & 16'h0070) == 16'h0000 || reg_rdata_out[`ST_ERR])
        else $error("error summary missing");
    AST_LOW_WHOLE: assert property ($rose(serial_tx_pin_out) |-> low_q != 16'h0000 && low_q % OVERSAMPLE == 0)
        else $error("low run not whole bits");
    AST_STOP_MIN: assert property ($fell(serial_tx_pin_out) |-> high_q >= OVERSAMPLE)
        else $error("start bit without a full stop bit before it");
    AST_RXBUF_CLR: assert property (rd_at(`REG_RXBUF) ##2 rd_at(`REG_STAT) |=> (reg_rdata_out & 16'h002A) == 16'h0000)
        else $error("rx buffer read left flags set");
endmodule : uart_mp_checker
bind uart_multiprocessor_core uart_mp_checker #(.OVERSAMPLE(OVERSAMPLE)) chk (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .serial_rx_pin_in(serial_rx_pin_in),
    .serial_tx_pin_out(serial_tx_pin_out));

// ---- tb/serial_station.sv ----
// Remote serial station: drives the receive line and captures the transmit line.
`timescale 1ns/10ps
module serial_station #(
    parameter int BIT_CLKS = 4
) (
    input  wire logic ref_clk_in,
    input  wire logic tx_line_in,
    output logic      rx_line_out
);
    initial rx_line_out = 1'b1;
    // Sends n bits, bit 0 first, one bit time each; the line then rests at mark.
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++)
            repeat (BIT_CLKS) @(posedge ref_clk_in) rx_line_out <= bits[i];
        @(posedge ref_clk_in) rx_line_out <= 1'b1;
    endtask : send
    // Counts cycles to the start edge, then samples n bits at their middles.
    task automatic grab(input int n, output logic [11:0] bits, output int gap);
        gap = 0;
        bits = 12'h000;
        while (tx_line_in === 1'b1 && gap < 5000)
            @(negedge ref_clk_in) gap++;
        repeat (BIT_CLKS / 2) @(negedge ref_clk_in);
        for (int i = 0; i < n; i++)
        begin
            bits[i] = tx_line_in;
            repeat (BIT_CLKS) @(negedge ref_clk_in);
        end
    endtask : grab
endmodule : serial_station

// ---- tb/tb_top.sv ----
// Self-checking bench of the serial core against a remote station model.
`timescale 1ns/10ps
`include "uart_mp_defs.svh"
module tb_top;
    localparam int OS = 4;
    logic        ref_clk;
    logic        rst_b;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        rx;
    logic        tx;
    logic [15:0] v;
    logic [11:0] bits;
    int          gap;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    uart_multiprocessor_core #(.OVERSAMPLE(OS)) DUT (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .serial_rx_pin_in(rx),
        .serial_tx_pin_out(tx));
    serial_station #(.BIT_CLKS(OS)) st (.ref_clk_in(ref_clk), .tx_line_in(tx), .rx_line_out(rx));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Configures under soft reset with the shortest bit time, then releases.
    task automatic cfg(input logic [15:0] c);
        wr_reg(`REG_CTRL, c | 16'h0001);
        wr_reg(`REG_BAUD, 16'h0000);
        wr_reg(`REG_CTRL, c);
    endtask : cfg
    task automatic t_reset();
        rd_reg(`REG_CTRL, v);
        check(v, 16'h0001, "ctrl after reset");
        wr_reg(`REG_IE, 16'h000F);
        rd_reg(`REG_IE, v);
        check(v & 16'h0003, 16'h0000, "enables under soft reset");
        rd_reg(`REG_STAT, v);
        check(v & 16'h067F, 16'h0001, "status under soft reset");
        rd_reg(4'hF, v);
        check(v, 16'h0000, "unmapped read");
        $display("reset test done");
    endtask : t_reset
    task automatic t_tx(input logic [15:0] c, input logic [15:0] f, input logic [7:0] d, input int n,
                        input logic [11:0] e, input int gmin);
        cfg(c);
        wr_reg(`REG_CTRL, c | f);
        rd_reg(`REG_STAT, v);
        check(v & 16'h0001, 16'h0001, "tx buffer empty before write");
        wr_reg(`REG_TXBUF, {8'h00, d});
        st.grab(n, bits, gap);
        check({4'h0, bits}, {4'h0, e}, "tx frame");
        check({15'h0000, gap >= gmin && gap <= gmin + 2 * OS}, 16'h0001, "tx lead time");
        rd_reg(`REG_CTRL, v);
        check(v & f, 16'h0000, "tx flag not cleared");
        repeat (3 * OS) @(posedge ref_clk);
        $display("tx test done %h", c | f);
    endtask : t_tx
    task automatic t_rx(input logic [15:0] c, input logic [11:0] f, input int n, input logic [15:0] m,
                        input logic [15:0] s, input logic [7:0] d);
        cfg(c);
        wr_reg(`REG_IE, 16'h0009);
        st.send(f, n);
        repeat (2 * OS) @(posedge ref_clk);
        rd_reg(`REG_STAT, v);
        check(v & m, s, "rx status");
        rd_reg(`REG_RXBUF, v);
        if (s[`ST_RXF])
            check(v, {8'h00, d}, "rx data");
        rd_reg(`REG_STAT, v);
        check(v & 16'h0002, 16'h0000, "rx flag after buffer read");
        rd_reg(`REG_CTRL, v);
        check(v & 16'h0200, c & 16'h0200, "dormant bit changed");
        $display("rx test done %h", c);
    endtask : t_rx
    // Idle-line receive while dormant: only the frame after a long mark gap is an address.
    task automatic t_idle();
        cfg(16'h0280);
        wr_reg(`REG_IE, 16'h0009);
        st.send(12'h284, 10);
        repeat (12 * OS) @(posedge ref_clk);
        rd_reg(`REG_STAT, v);
        check(v & 16'h0082, 16'h0080, "idle seen, data dropped");
        st.send(12'h2A6, 10);
        repeat (2 * OS) @(posedge ref_clk);
        rd_reg(`REG_STAT, v);
        check(v & 16'h0082, 16'h0082, "address after idle");
        rd_reg(`REG_RXBUF, v);
        check(v, 16'h0053, "address data");
        $display("idle test done");
    endtask : t_idle
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial
    begin
        rst_b = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_tx(16'h0000, 16'h0000, 8'hB4, 10, 12'h368, 0);
        t_tx(16'h0004, 16'h0000, 8'hB4, 10, 12'h25A, 0);
        t_tx(16'h0100, 16'h0400, 8'h3C, 11, 12'h678, 0);
        t_tx(16'h0080, 16'h0400, 8'h5A, 10, 12'h2B4, 11 * OS);
        t_tx(16'h0000, 16'h0800, 8'h00, 10, 12'h000, 0);
        t_rx(16'h0300, 12'h484, 11, 16'h0002, 16'h0000, 8'h42);
        t_rx(16'h0300, 12'h684, 11, 16'h0102, 16'h0102, 8'h42);
        t_rx(16'h0100, 12'h484, 11, 16'h0102, 16'h0002, 8'h42);
        t_rx(16'h0000, 12'h000, 10, 16'h000A, 16'h000A, 8'h00);
        t_rx(16'h0000, 12'h0AA, 10, 16'h0046, 16'h0046, 8'h55);
        t_idle();
        conclude();
    end
endmodule : tb_top
